// file: dv/dshbp_monitor.sv
`timescale 1ns/1ps
module dshbp_monitor
	import dshbp_pkg::*;
(
	// clock and reset
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic                    ce,
	// bus pins
	input wire logic                    bus_style,
	input wire logic                    read_strobe_n,
	input wire logic                    write_strobe_n,
	input wire logic                    channel_a_select_n,
	input wire logic                    channel_b_select_n,
	input wire logic [DSHBP_ADDR_W-1:0] register_address,
	input wire logic [DSHBP_DATA_W-1:0] host_dq_o,
	input wire logic                    host_dq_oe_n,
	input wire logic                    dev_dq_oe_n,
	input wire logic                    dev_irq_a_o,
	input wire logic                    dev_irq_a_oe_n,
	input wire logic                    dev_irq_b_oe_n
);
	wire sel_any = bus_style ? !(channel_a_select_n && channel_b_select_n) : !channel_a_select_n;
	wire rd_act  = sel_any && (bus_style ? !read_strobe_n : write_strobe_n);
	wire wr_act  = sel_any && !write_strobe_n;
	logic [3:0] rd_low_q;

	// enabled cycles with the read strobe low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			rd_low_q <= 4'h0;
		else if (read_strobe_n)
			rd_low_q <= 4'h0;
		else if (ce)
			rd_low_q <= rd_low_q + 4'h1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_idle_release: assert property (!sel_any |-> dev_dq_oe_n)
		else $error("data bus driven without select");
	chk_read_drive: assert property (rd_act && $past(rd_act) && $past(ce) |-> !dev_dq_oe_n)
		else $error("read data not driven");
	chk_oe_cause: assert property (!dev_dq_oe_n |-> rd_act)
		else $error("data driven outside a read");
	chk_no_contend: assert property (!dev_dq_oe_n |-> host_dq_oe_n)
		else $error("both ends drive the data bus");
	chk_write_data: assert property (wr_act |-> !host_dq_oe_n)
		else $error("write without host data");
	chk_write_stable: assert property (wr_act && $past(wr_act) |-> $stable(host_dq_o) && $stable(register_address))
		else $error("write data or address moved");
	chk_strobe_width: assert property ($rose(read_strobe_n) |-> rd_low_q == 4'(DSHBP_STROBE_CYC))
		else $error("read strobe width wrong");
	chk_ce_freeze: assert property (!ce |=> $stable(read_strobe_n) && $stable(write_strobe_n)
		&& $stable(channel_a_select_n) && $stable(channel_b_select_n)
		&& $stable(dev_dq_oe_n) && $stable(dev_irq_a_oe_n))
		else $error("pins moved while clock enable low");
	chk_one_select: assert property (bus_style && !channel_a_select_n |-> channel_b_select_n)
		else $error("both channel selects low");
	chk_shared_irq: assert property ((!bus_style) [*2] |-> dev_irq_b_oe_n && (dev_irq_a_oe_n || !dev_irq_a_o))
		else $error("shared interrupt not open drain");
endmodule

// file: dv/dual_style_host_bus_port_tb.sv
`timescale 1ns/1ps
module dual_style_host_bus_port_tb;
	import dshbp_pkg::*;

	logic                    clk_sys;
	logic                    rst;
	logic                    style_sel;
	logic                    cmd_valid;
	logic                    cmd_ready;
	logic                    cmd_write;
	logic                    cmd_chan;
	logic [DSHBP_ADDR_W-1:0] cmd_addr;
	logic [DSHBP_DATA_W-1:0] cmd_wdata;
	logic                    rsp_valid;
	logic [DSHBP_DATA_W-1:0] rsp_data;
	logic                    irq_pending;
	logic [DSHBP_NCHAN-1:0]  chan_irq;
	logic                    peek_chan;
	logic [DSHBP_ADDR_W-1:0] peek_addr;
	logic [DSHBP_DATA_W-1:0] peek_data;
	logic                    evt_chan;
	logic [DSHBP_ADDR_W-1:0] evt_addr;
	logic [DSHBP_DATA_W-1:0] evt_data;
	logic [DSHBP_DATA_W-1:0] mdl [DSHBP_NCHAN][DSHBP_NREG];
	logic                    ce;
	logic                    ce_jit;
	logic                    wr_evt;
	logic                    rd_evt;
	int                      n_wr_evt;
	int                      n_rd_evt;
	int                      failures;
	int                      n_tests;
	int                      seed;

	dshbp_if bus ();

	dshbp_host_end i_dshbp_host_end (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus),
		.style_sel(style_sel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_chan(cmd_chan), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .irq_pending(irq_pending));

	dshbp_dev_end i_dshbp_dev_end (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus),
		.chan_irq(chan_irq), .peek_chan(peek_chan), .peek_addr(peek_addr), .peek_data(peek_data),
		.wr_evt(wr_evt), .rd_evt(rd_evt), .evt_chan(evt_chan), .evt_addr(evt_addr), .evt_data(evt_data));

	dshbp_monitor i_dshbp_monitor (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_style(bus.bus_style),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.channel_a_select_n(bus.channel_a_select_n), .channel_b_select_n(bus.channel_b_select_n),
		.register_address(bus.register_address), .host_dq_o(bus.host_dq_o),
		.host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n), .dev_irq_a_o(bus.dev_irq_a_o),
		.dev_irq_a_oe_n(bus.dev_irq_a_oe_n), .dev_irq_b_oe_n(bus.dev_irq_b_oe_n));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// clock enable stalls in the random passes, event pulses counted per enabled cycle
	always @(posedge clk_sys) begin
		ce <= !ce_jit || (2'($random(seed)) != 2'h0);
		if (ce === 1'b1 && wr_evt === 1'b1)
			n_wr_evt++;
		if (ce === 1'b1 && rd_evt === 1'b1)
			n_rd_evt++;
	end

	task automatic summarize();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wait_ready();
		for (int k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (cmd_ready === 1'b1)
				return;
		end
		failures++;
		summarize();
	endtask

	task automatic do_cmd(input logic wr, input logic ch, input logic [2:0] ad, input logic [7:0] wd);
		int k;
		int wr0;
		int rd0;
		wait_ready();
		wr0 = n_wr_evt;
		rd0 = n_rd_evt;
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_chan  <= ch;
		cmd_addr  <= ad;
		cmd_wdata <= wd;
		chan_irq  <= 2'($random(seed));
		peek_chan <= 1'($random(seed));
		peek_addr <= 3'($random(seed));
		// hold the request until an enabled edge takes it
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ce !== 1'b1 && k < 100);
		cmd_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (rsp_valid !== 1'b1 && k < 100);
		if (k >= 100) begin
			failures++;
			summarize();
		end
		if (wr)
			mdl[ch][ad] = wd;
		else
			chk(rsp_data, mdl[ch][ad], "read data");
		wait_ready();
		if (wr)
			chk({evt_chan, evt_addr, evt_data}, {ch, ad, wd}, "stored write");
		else
			chk({evt_chan, evt_addr, evt_data}, {ch, ad, mdl[ch][ad]}, "read event");
		chk(12'(n_wr_evt - wr0), 12'(wr), "write event count");
		chk(12'(n_rd_evt - rd0), 12'(!wr), "read event count");
		chk(peek_data, mdl[peek_chan][peek_addr], "register set");
		chk(irq_pending, |chan_irq, "interrupt");
	endtask

	initial begin
		logic [3:0] ix;
		logic       wr;
		seed      = 12;
		failures  = 0;
		n_tests   = 0;
		n_wr_evt  = 0;
		n_rd_evt  = 0;
		ce        = 1'b1;
		ce_jit    = 1'b0;
		rst       = 1'b1;
		style_sel = DSHBP_STYLE_STROBE;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_chan  = 1'b0;
		cmd_addr  = '0;
		cmd_wdata = '0;
		chan_irq  = '0;
		peek_chan = 1'b0;
		peek_addr = '0;
		foreach (mdl[c, a])
			mdl[c][a] = DSHBP_REG_RESET;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		// strobe style first, then rw-line style starting again from reset values
		for (int s = 0; s < 2; s++) begin
			style_sel <= (s == 0) ? DSHBP_STYLE_STROBE : DSHBP_STYLE_RWLINE;
			// mid-run reset before the rw-line passes, first pass reads reset values
			if (s == 1) begin
				rst <= 1'b1;
				repeat (3) @(posedge clk_sys);
				rst <= 1'b0;
				foreach (mdl[c, a])
					mdl[c][a] = DSHBP_REG_RESET;
			end
			repeat (2) @(posedge clk_sys);
			// passes: read all, write all, read all, random mix with clock enable stalls
			for (int p = 0; p < 4; p++) begin
				ce_jit <= (p == 3);
				for (int i = 0; i < 16; i++) begin
					ix = (p == 3) ? 4'($random(seed)) : 4'(i);
					wr = (p == 3) ? 1'($random(seed)) : (p == 1);
					do_cmd(wr, ix[3], ix[2:0], (i == 0) ? 8'hFF : (i == 15) ? 8'h00 : 8'($random(seed)));
				end
			end
		end
		summarize();
	end
endmodule

// file: hdl/dshbp_dev_end.sv
// Functional notes
// - style pin high strobe, low rw-line
// - three-bit address picks channel register
// - eight-bit shared data bus, device drives reads
// - read strobe fall reads, host takes at rise
// - write strobe rise stores held data byte
// - strobe style: separate active-low channel selects
// - rw line high reads, low writes
// - channel A select is device select
// - channel B select is channel address bit
// - rw-line style ignores read strobe
// - two channels with independent register sets
// - rw-line style: one open-drain device interrupt
`timescale 1ns/1ps
module dshbp_dev_end
	import dshbp_pkg::*;
(
	// clock, reset, enable
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    ce,
	// host bus pins
	dshbp_if.dev                         bus,
	// interrupt requests from the channels
	input  wire logic [DSHBP_NCHAN-1:0]  chan_irq,
	// register peek for channel logic
	input  wire logic                    peek_chan,
	input  wire logic [DSHBP_ADDR_W-1:0] peek_addr,
	output logic      [DSHBP_DATA_W-1:0] peek_data,
	// access events
	output logic                         wr_evt,
	output logic                         rd_evt,
	output logic                         evt_chan,
	output logic      [DSHBP_ADDR_W-1:0] evt_addr,
	output logic      [DSHBP_DATA_W-1:0] evt_data
);

	// pin decode
	logic                    style_strobe;
	logic                    chan_now;
	logic                    acc_now;
	logic                    rd_now;
	logic                    wr_now;
	logic                    rd_start;
	logic                    wr_commit;

	// sampled access state
	logic                    rd_q;
	logic                    wr_q;
	logic                    chan_q;
	logic [DSHBP_ADDR_W-1:0] addr_q;
	logic [DSHBP_DATA_W-1:0] din_q;
	logic                    drv_q;
	logic [DSHBP_DATA_W-1:0] rdata_q;
	logic [DSHBP_NCHAN-1:0]  irq_q;

	// event outputs
	logic                    wr_evt_q;
	logic                    rd_evt_q;
	logic                    evt_chan_q;
	logic [DSHBP_ADDR_W-1:0] evt_addr_q;
	logic [DSHBP_DATA_W-1:0] evt_data_q;
	logic [DSHBP_DATA_W-1:0] peek_q;

	// per-channel read views
	logic [DSHBP_DATA_W-1:0] rd_mux   [DSHBP_NCHAN];
	logic [DSHBP_DATA_W-1:0] peek_mux [DSHBP_NCHAN];

	assign style_strobe = (bus.bus_style == DSHBP_STYLE_STROBE);

	// strobe style channel select
	// both selects low falls to channel A
	// rw-line style channel address bit
	assign chan_now = style_strobe ? bus.channel_a_select_n
		: bus.channel_b_select_n;

	// single device select in rw style
	assign acc_now = style_strobe
		? (!bus.channel_a_select_n || !bus.channel_b_select_n)
		: !bus.channel_a_select_n;

	// read strobe unused in rw style
	assign rd_now = acc_now && (style_strobe ? !bus.read_strobe_n
		: bus.write_strobe_n);

	// write strobe low or rw line low
	assign wr_now = acc_now && !bus.write_strobe_n;

	assign rd_start = rd_now && !rd_q;

	assign wr_commit = wr_q && !wr_now;

	// sample pins each cycle of an access
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_q   <= 1'b0;
			wr_q   <= 1'b0;
			chan_q <= 1'b0;
			addr_q <= '0;
			din_q  <= DSHBP_REG_RESET;
		end else if (ce) begin
			rd_q   <= rd_now;
			wr_q   <= wr_now;
			chan_q <= chan_now;
			addr_q <= bus.register_address;
			din_q  <= bus.host_data_bus;
		end
	end

	for (genvar c = 0; c < DSHBP_NCHAN; c++) begin : g_chan
		logic [DSHBP_DATA_W-1:0] regs_q [DSHBP_NREG];
		logic                    we;

		assign we = wr_commit && (chan_q == 1'(c));

		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				for (int r = 0; r < DSHBP_NREG; r++) begin
					regs_q[r] <= DSHBP_REG_RESET;
				end
			end else if (ce && we) begin
				regs_q[addr_q] <= din_q;
			end
		end

		assign rd_mux[c]   = regs_q[bus.register_address];
		assign peek_mux[c] = regs_q[peek_addr];
	end

	// latch addressed byte at read start
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= DSHBP_REG_RESET;
			drv_q   <= 1'b0;
		end else if (ce) begin
			if (rd_start) begin
				rdata_q <= rd_mux[chan_now];
			end
			drv_q <= rd_now;
		end
	end

	// released once select or strobe drops
	assign bus.dev_dq_o    = rdata_q;
	assign bus.dev_dq_oe_n = !(rd_now && drv_q);

	// access events toward channel logic
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_evt_q   <= 1'b0;
			rd_evt_q   <= 1'b0;
			evt_chan_q <= 1'b0;
			evt_addr_q <= '0;
			evt_data_q <= DSHBP_REG_RESET;
		end else if (ce) begin
			wr_evt_q <= wr_commit;
			rd_evt_q <= rd_start;
			if (wr_commit) begin
				evt_chan_q <= chan_q;
				evt_addr_q <= addr_q;
				evt_data_q <= din_q;
			end else if (rd_start) begin
				evt_chan_q <= chan_now;
				evt_addr_q <= bus.register_address;
				evt_data_q <= rd_mux[chan_now];
			end
		end
	end

	assign wr_evt   = wr_evt_q;
	assign rd_evt   = rd_evt_q;
	assign evt_chan = evt_chan_q;
	assign evt_addr = evt_addr_q;
	assign evt_data = evt_data_q;

	// register peek
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			peek_q <= DSHBP_REG_RESET;
		end else if (ce) begin
			peek_q <= peek_mux[peek_chan];
		end
	end

	assign peek_data = peek_q;

	// interrupt requests
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_q <= '0;
		end else if (ce) begin
			irq_q <= chan_irq;
		end
	end

	// strobe style: one push-pull pin per channel
	// rw style: shared open drain, B unused
	assign bus.dev_irq_a_o    = style_strobe ? irq_q[0] : 1'b0;
	assign bus.dev_irq_a_oe_n = style_strobe ? 1'b0 : !(|irq_q);
	assign bus.dev_irq_b_o    = style_strobe ? irq_q[1] : 1'b0;
	assign bus.dev_irq_b_oe_n = !style_strobe;

endmodule

// file: hdl/dshbp_host_end.sv
`timescale 1ns/1ps
module dshbp_host_end
	import dshbp_pkg::*;
(
	// clock, reset, enable
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    ce,
	// host bus pins
	dshbp_if.host                        bus,
	// style strap
	input  wire logic                    style_sel,
	// command
	input  wire logic                    cmd_valid,
	output logic                         cmd_ready,
	input  wire logic                    cmd_write,
	input  wire logic                    cmd_chan,
	input  wire logic [DSHBP_ADDR_W-1:0] cmd_addr,
	input  wire logic [DSHBP_DATA_W-1:0] cmd_wdata,
	// response
	output logic                         rsp_valid,
	output logic      [DSHBP_DATA_W-1:0] rsp_data,
	// interrupt status
	output logic                         irq_pending
);

	dshbp_state_t            state_q;
	logic [3:0]              cnt_q;
	logic                    style_q;
	logic                    write_q;
	logic                    rd_n_q;
	logic                    wr_n_q;
	logic                    csa_n_q;
	logic                    csb_n_q;
	logic [DSHBP_ADDR_W-1:0] addr_q;
	logic [DSHBP_DATA_W-1:0] wdata_q;
	logic                    dq_oe_n_q;
	logic                    rsp_valid_q;
	logic [DSHBP_DATA_W-1:0] rsp_data_q;
	logic                    irq_q;
	logic                    strobe_style;
	logic                    take;
	logic                    irq_now;

	assign strobe_style = (style_q == DSHBP_STYLE_STROBE);
	assign cmd_ready    = (state_q == DSHBP_IDLE);
	assign take         = ce && cmd_valid && cmd_ready;
	assign irq_now      = strobe_style ? (bus.channel_a_irq || bus.channel_b_irq)
		: !bus.channel_a_irq;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q     <= DSHBP_IDLE;
			cnt_q       <= '0;
			style_q     <= DSHBP_STYLE_STROBE;
			write_q     <= 1'b0;
			rd_n_q      <= 1'b1;
			wr_n_q      <= 1'b1;
			csa_n_q     <= 1'b1;
			csb_n_q     <= 1'b1;
			addr_q      <= '0;
			wdata_q     <= DSHBP_BUS_IDLE;
			dq_oe_n_q   <= 1'b1;
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= DSHBP_BUS_IDLE;
			irq_q       <= 1'b0;
		end else if (ce) begin
			rsp_valid_q <= 1'b0;
			irq_q       <= irq_now;
			unique case (state_q)
				DSHBP_IDLE: begin
					style_q <= style_sel;
					if (take) begin
						write_q   <= cmd_write;
						addr_q    <= cmd_addr;
						wdata_q   <= cmd_wdata;
						dq_oe_n_q <= !cmd_write;
						if (style_sel == DSHBP_STYLE_STROBE) begin
							csa_n_q <= cmd_chan;
							csb_n_q <= !cmd_chan;
						end else begin
							wr_n_q  <= !cmd_write;
							csb_n_q <= cmd_chan;
						end
						state_q <= DSHBP_SETUP;
					end
				end
				DSHBP_SETUP: begin
					cnt_q <= DSHBP_STROBE_CNT;
					if (strobe_style) begin
						rd_n_q <= write_q;
						wr_n_q <= !write_q;
					end else begin
						csa_n_q <= 1'b0;
					end
					state_q <= DSHBP_STROBE;
				end
				DSHBP_STROBE: begin
					if (cnt_q == 4'h0) begin
						if (!write_q) begin
							rsp_data_q <= bus.host_data_bus;
						end
						rsp_valid_q <= 1'b1;
						if (strobe_style) begin
							rd_n_q <= 1'b1;
							wr_n_q <= 1'b1;
						end else begin
							csa_n_q <= 1'b1;
						end
						state_q <= DSHBP_END;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				DSHBP_END: begin
					csa_n_q   <= 1'b1;
					csb_n_q   <= 1'b1;
					wr_n_q    <= 1'b1;
					dq_oe_n_q <= 1'b1;
					cnt_q     <= DSHBP_GAP_CNT;
					state_q   <= DSHBP_GAP;
				end
				DSHBP_GAP: begin
					if (cnt_q == 4'h0) begin
						state_q <= DSHBP_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
			endcase
		end
	end

	assign bus.bus_style          = style_q;
	assign bus.read_strobe_n      = rd_n_q;
	assign bus.write_strobe_n     = wr_n_q;
	assign bus.channel_a_select_n = csa_n_q;
	assign bus.channel_b_select_n = csb_n_q;
	assign bus.register_address   = addr_q;
	assign bus.host_dq_o          = wdata_q;
	assign bus.host_dq_oe_n       = dq_oe_n_q;
	assign rsp_valid              = rsp_valid_q;
	assign rsp_data               = rsp_data_q;
	assign irq_pending            = irq_q;

endmodule

// file: hdl/dshbp_if.sv
`timescale 1ns/1ps
interface dshbp_if;
	import dshbp_pkg::*;

	// static style select, high picks strobe style
	logic                    bus_style;
	// control pins
	logic                    read_strobe_n;
	logic                    write_strobe_n;
	logic                    channel_a_select_n;
	logic                    channel_b_select_n;
	logic [DSHBP_ADDR_W-1:0] register_address;
	// data bus halves and resolved wire
	logic [DSHBP_DATA_W-1:0] host_dq_o;
	logic                    host_dq_oe_n;
	logic [DSHBP_DATA_W-1:0] dev_dq_o;
	logic                    dev_dq_oe_n;
	logic [DSHBP_DATA_W-1:0] host_data_bus;
	// interrupt pins
	logic                    dev_irq_a_o;
	logic                    dev_irq_a_oe_n;
	logic                    dev_irq_b_o;
	logic                    dev_irq_b_oe_n;
	logic                    channel_a_irq;
	logic                    channel_b_irq;

	// released lines float high through pull-ups
	assign host_data_bus = !dev_dq_oe_n ? dev_dq_o :
		(!host_dq_oe_n ? host_dq_o : DSHBP_BUS_IDLE);
	assign channel_a_irq = dev_irq_a_oe_n ? 1'b1 : dev_irq_a_o;
	assign channel_b_irq = dev_irq_b_oe_n ? 1'b1 : dev_irq_b_o;

	modport dev (
		input  bus_style, read_strobe_n, write_strobe_n,
		input  channel_a_select_n, channel_b_select_n,
		input  register_address, host_data_bus,
		output dev_dq_o, dev_dq_oe_n,
		output dev_irq_a_o, dev_irq_a_oe_n, dev_irq_b_o, dev_irq_b_oe_n
	);

	modport host (
		output bus_style, read_strobe_n, write_strobe_n,
		output channel_a_select_n, channel_b_select_n,
		output register_address, host_dq_o, host_dq_oe_n,
		input  host_data_bus, channel_a_irq, channel_b_irq
	);

endinterface

// file: hdl/dshbp_pkg.sv
package dshbp_pkg;

	// bus geometry
	localparam int unsigned DSHBP_NCHAN  = 2;
	localparam int unsigned DSHBP_ADDR_W = 3;
	localparam int unsigned DSHBP_DATA_W = 8;
	localparam int unsigned DSHBP_NREG   = 8;

	// bus style select levels
	localparam logic DSHBP_STYLE_STROBE = 1'b1;
	localparam logic DSHBP_STYLE_RWLINE = 1'b0;

	// values
	localparam logic [7:0] DSHBP_REG_RESET = 8'h00;
	localparam logic [7:0] DSHBP_BUS_IDLE  = 8'hFF;

	// timing
	localparam int unsigned DSHBP_CLK_NS     = 10;
	localparam int unsigned DSHBP_STROBE_NS  = 30;
	localparam int unsigned DSHBP_GAP_NS     = 20;
	localparam int unsigned DSHBP_STROBE_CYC = (DSHBP_STROBE_NS + DSHBP_CLK_NS - 1) / DSHBP_CLK_NS;
	localparam int unsigned DSHBP_GAP_CYC    = (DSHBP_GAP_NS + DSHBP_CLK_NS - 1) / DSHBP_CLK_NS;
	localparam logic [3:0]  DSHBP_STROBE_CNT = 4'(DSHBP_STROBE_CYC - 1);
	localparam logic [3:0]  DSHBP_GAP_CNT    = 4'(DSHBP_GAP_CYC - 1);

	// host sequencer states
	typedef enum logic [2:0] {
		DSHBP_IDLE,
		DSHBP_SETUP,
		DSHBP_STROBE,
		DSHBP_END,
		DSHBP_GAP
	} dshbp_state_t;

endpackage
